// ### design/ushb_pkg.sv
// Package: register map, field positions, modes and timing for the serial port block
`default_nettype none
package ushb_pkg;
  // Register offsets (byte addresses)
  localparam logic [7:0] ADDR_CTRL      = 8'h00;
  localparam logic [7:0] ADDR_MODE      = 8'h04;
  localparam logic [7:0] ADDR_BAUD      = 8'h08;
  localparam logic [7:0] ADDR_STATUS    = 8'h0C;
  localparam logic [7:0] ADDR_IRQ_EN    = 8'h10;
  localparam logic [7:0] ADDR_IRQ_CLR   = 8'h14;
  localparam logic [7:0] ADDR_TX_DATA   = 8'h18;
  localparam logic [7:0] ADDR_RX_DATA   = 8'h1C;
  localparam logic [7:0] ADDR_DMA_CNT0  = 8'h20;
  localparam logic [7:0] ADDR_DMA_CNT1  = 8'h24;
  localparam logic [7:0] ADDR_LINE      = 8'h28;
  // Control register bits
  localparam int CTRL_RX_EN  = 0;
  localparam int CTRL_TX_EN  = 1;
  localparam int CTRL_DMA_EN = 2;
  // Mode register field
  localparam int MODE_LSB = 0;
  localparam int MODE_W   = 2;
  localparam logic [1:0] MODE_NORMAL    = 2'h0;
  localparam logic [1:0] MODE_HANDSHAKE = 2'h1;
  localparam logic [1:0] MODE_MODEM     = 2'h2;
  // Status / interrupt bit positions
  localparam int ST_RX_READY  = 0;
  localparam int ST_TX_READY  = 1;
  localparam int ST_BREAK     = 2;
  localparam int ST_FRAME_ERR = 3;
  localparam int ST_OVERRUN   = 4;
  localparam int ST_BUF_FULL  = 5;
  localparam int ST_W         = 6;
  // Reset values
  localparam logic [15:0] BAUD_RESET = 16'h0036;
  localparam logic [15:0] CNT_RESET  = 16'h0000;
  // Oversampling of one bit time
  localparam int OVERSAMPLE = 16;
  localparam int HALF_BIT   = OVERSAMPLE / 2;
  typedef enum logic [2:0] {
    USHB_RX_IDLE, USHB_RX_START, USHB_RX_DATA, USHB_RX_STOP, USHB_RX_BREAK
  } ushb_rx_state_type;
endpackage
`default_nettype wire

// ### design/ushb_rx_frame.sv
// Receive framer: start, data, one stop, break and framing error detection
`default_nettype none
module ushb_rx_frame
  import ushb_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Control
  input  wire logic              enable,
  input  wire logic              tick,
  // Line
  input  wire logic              rxd,
  // Results
  output logic [DATA_W-1:0]      data,
  output logic                   data_valid,
  output logic                   frame_err,
  output logic                   break_seen
);
  ushb_rx_state_type state;
  logic [4:0]        os_cnt;
  logic [3:0]        bit_cnt;
  logic              all_zero;
  logic              guard_ok;

  // ==================================================================
  // Framing
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      state      <= USHB_RX_IDLE;
      os_cnt     <= 5'h00;
      bit_cnt    <= 4'h0;
      all_zero   <= 1'b0;
      guard_ok   <= 1'b1;
      data       <= '0;
      data_valid <= 1'b0;
      frame_err  <= 1'b0;
      break_seen <= 1'b0;
    end else begin
      data_valid <= 1'b0;
      frame_err  <= 1'b0;
      break_seen <= 1'b0;
      if (!enable) begin
        state <= USHB_RX_IDLE;
      end else if (tick) begin
        unique case (state)
          USHB_RX_IDLE: begin
            // One bit time of idle line counts as guard before the next frame
            if (!rxd) begin
              os_cnt <= 5'h00;
              state  <= USHB_RX_START;
            end else if (os_cnt == 5'(OVERSAMPLE - 1)) begin
              guard_ok <= 1'b1;
            end else begin
              os_cnt <= os_cnt + 5'h01;
            end
          end
          USHB_RX_START: begin
            if (os_cnt == 5'(HALF_BIT - 1)) begin
              os_cnt   <= 5'h00;
              bit_cnt  <= 4'h0;
              all_zero <= 1'b1;
              state    <= rxd ? USHB_RX_IDLE : USHB_RX_DATA;
            end else begin
              os_cnt <= os_cnt + 5'h01;
            end
          end
          USHB_RX_DATA: begin
            if (os_cnt == 5'(OVERSAMPLE - 1)) begin
              os_cnt   <= 5'h00;
              data     <= {rxd, data[DATA_W-1:1]};
              all_zero <= all_zero & ~rxd;
              if (bit_cnt == 4'(DATA_W - 1)) begin
                state <= USHB_RX_STOP;
              end else begin
                bit_cnt <= bit_cnt + 4'h1;
              end
            end else begin
              os_cnt <= os_cnt + 5'h01;
            end
          end
          USHB_RX_STOP: begin
            // Only this single stop sample is judged
            if (os_cnt == 5'(OVERSAMPLE - 1)) begin
              os_cnt <= 5'h00;
              guard_ok <= 1'b0;
              if (rxd) begin
                data_valid <= 1'b1;
                state      <= USHB_RX_IDLE;
              end else if (all_zero && guard_ok) begin
                frame_err <= 1'b1;
                state     <= USHB_RX_BREAK;
              end else begin
                // Break straight after a stop, with no guard: framing error only  [RULE3]
                frame_err <= 1'b1;
                state     <= USHB_RX_IDLE;
              end
            end else begin
              os_cnt <= os_cnt + 5'h01;
            end
          end
          USHB_RX_BREAK: begin
            // Line back high with no valid data: flag break and go idle on the same tick  [RULE4]
            if (rxd) begin
              break_seen <= 1'b1;
              state      <= USHB_RX_IDLE;
            end
          end
          default: state <= USHB_RX_IDLE;
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ### design/ushb_core.sv
// Serial port core: registers, transmitter, handshake, carrier detect, DMA counters
// ==================================================================
// Functional notes
// [RULE1] In modem and handshake modes the transmit line rests high via pull-up.
// [RULE2] Modem carrier detect is treated as asserted when the input is high.
// [RULE3] Back-to-back characters into a break yield framing error, no break flag.
// [RULE4] Only one stop is checked; after it, idle, then break flagged.
// [RULE5] Far transmitter adds guard time or two stops before a break.
// [RULE6] Selecting handshake mode drives request-to-send low even if receiver off.
// [RULE7] Software fully configures the port before selecting handshake mode.
// [RULE8] Disabling receiver mid-DMA with buffer-full clear leaves request-to-send.
// [RULE9] Request-to-send rises then only once both DMA counters are written zero.
// [RULE10] In handshake mode request-to-send high when full, low when able.
//
// The implementer's own choices: the register offsets and strobed register access.
`default_nettype none
module ushb_core
  import ushb_pkg::*;
#(
  parameter int DATA_W = 8
) (
  // Clock and reset
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Register port
  input  wire logic [7:0]        addr,
  input  wire logic [31:0]       wdata,
  input  wire logic              wr,
  input  wire logic              rd,
  output logic [31:0]            rdata,
  // DMA receive channel
  output logic                   dma_rx_req,
  input  wire logic              dma_rx_ack,
  // Serial line
  input  wire logic              rxd,
  output logic                   txd,
  output logic                   txd_pullup_en,
  output logic                   rts_b,
  input  wire logic              carrier_detect_input,
  output logic                   carrier_present,
  // Interrupt
  output logic                   irq
);
  logic [31:0]       ctrl;
  logic [MODE_W-1:0] mode;
  logic [15:0]       baud;
  logic [15:0]       dma_cnt0;
  logic [15:0]       dma_cnt1;
  logic [ST_W-1:0]   status;
  logic [ST_W-1:0]   irq_en;
  logic [ST_W-1:0]   next_status;
  logic [15:0]       div_cnt;
  logic              tick;
  logic [DATA_W-1:0] rx_hold;
  logic              rx_full;
  logic [DATA_W-1:0] rx_data;
  logic              rx_valid;
  logic              rx_ferr;
  logic              rx_brk;
  logic [DATA_W+1:0] tx_shift;
  logic [3:0]        tx_bits;
  logic [4:0]        tx_os;
  logic              tx_busy;
  logic              rts_hold;
  logic              dma_on;
  logic              buf_full;

  wire wr_ctrl = wr && addr == ADDR_CTRL;
  wire rx_on   = ctrl[CTRL_RX_EN];
  wire hs_mode = mode == MODE_HANDSHAKE;
  assign dma_on   = ctrl[CTRL_DMA_EN];
  assign buf_full = dma_on && dma_cnt0 == CNT_RESET && dma_cnt1 == CNT_RESET;

  // ==================================================================
  // Registers written by software
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      ctrl   <= 32'h0000_0000;
      mode   <= MODE_NORMAL;
      baud   <= BAUD_RESET;
      irq_en <= '0;
    end else if (wr) begin
      unique case (addr)
        ADDR_CTRL:   ctrl   <= wdata;
        ADDR_MODE:   mode   <= wdata[MODE_LSB +: MODE_W];
        ADDR_BAUD:   baud   <= wdata[15:0];
        ADDR_IRQ_EN: irq_en <= wdata[ST_W-1:0];
        default: ;
      endcase
    end
  end

  // ==================================================================
  // Oversampling tick
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b0;
    end else if (div_cnt >= baud) begin
      div_cnt <= 16'h0000;
      tick    <= 1'b1;
    end else begin
      div_cnt <= div_cnt + 16'h0001;
      tick    <= 1'b0;
    end
  end

  ushb_rx_frame #(
    .DATA_W (DATA_W)
  ) u_rx (
    .clk_sys    (clk_sys),
    .rst_b      (rst_b),
    .enable     (rx_on),
    .tick       (tick),
    .rxd        (rxd),
    .data       (rx_data),
    .data_valid (rx_valid),
    .frame_err  (rx_ferr),
    .break_seen (rx_brk)
  );

  // ==================================================================
  // Receive holding register and DMA buffer counters
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rx_hold  <= '0;
      rx_full  <= 1'b0;
      dma_cnt0 <= CNT_RESET;
      dma_cnt1 <= CNT_RESET;
    end else begin
      if (rx_valid) begin
        rx_hold <= rx_data;
        rx_full <= 1'b1;
      end else if ((rd && addr == ADDR_RX_DATA) || dma_rx_ack) begin
        rx_full <= 1'b0;
      end
      // DMA ack drains the first buffer, then the second
      if (wr && addr == ADDR_DMA_CNT0) begin
        dma_cnt0 <= wdata[15:0];
      end else if (dma_rx_ack && dma_cnt0 != CNT_RESET) begin
        dma_cnt0 <= dma_cnt0 - 16'h0001;
      end
      if (wr && addr == ADDR_DMA_CNT1) begin
        dma_cnt1 <= wdata[15:0];
      end else if (dma_rx_ack && dma_cnt0 == CNT_RESET && dma_cnt1 != CNT_RESET) begin
        dma_cnt1 <= dma_cnt1 - 16'h0001;
      end
    end
  end

  assign dma_rx_req = dma_on && rx_full && !buf_full;

  // ==================================================================
  // Request-to-send
  // In handshake mode a receiver disable alone does not raise the line while DMA is live;
  // only zeroing both counters does, which drivers must know about.
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rts_hold <= 1'b0;
    end else if (wr && (addr == ADDR_DMA_CNT0 || addr == ADDR_DMA_CNT1)
                 && wdata[15:0] == CNT_RESET) begin
      rts_hold <= 1'b0; // [RULE9]
    end else if (wr_ctrl && rx_on && !wdata[CTRL_RX_EN] && dma_on && !buf_full) begin
      rts_hold <= 1'b1; // [RULE8]
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rts_b <= 1'b1;
    end else if (!hs_mode) begin
      rts_b <= !rx_on;
    end else if (rts_hold) begin
      rts_b <= 1'b0; // [RULE8]
    end else begin
      // Low as soon as the mode is set, regardless of receiver enable  [RULE6]
      rts_b <= rx_full || buf_full; // [RULE10]
    end
  end

  // ==================================================================
  // Transmitter
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      tx_shift <= '1;
      tx_bits  <= 4'h0;
      tx_os    <= 5'h00;
      tx_busy  <= 1'b0;
    end else if (!tx_busy) begin
      if (wr && addr == ADDR_TX_DATA && ctrl[CTRL_TX_EN]) begin
        tx_shift <= {1'b1, wdata[DATA_W-1:0], 1'b0};
        tx_bits  <= 4'(DATA_W + 1);
        tx_os    <= 5'h00;
        tx_busy  <= 1'b1;
      end
    end else if (tick) begin
      if (tx_os == 5'(OVERSAMPLE - 1)) begin
        tx_os    <= 5'h00;
        tx_shift <= {1'b1, tx_shift[DATA_W+1:1]};
        if (tx_bits == 4'h0) begin
          tx_busy <= 1'b0;
        end else begin
          tx_bits <= tx_bits - 4'h1;
        end
      end else begin
        tx_os <= tx_os + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      txd             <= 1'b1;
      txd_pullup_en   <= 1'b0;
      carrier_present <= 1'b0;
    end else begin
      txd             <= tx_busy ? tx_shift[0] : 1'b1;
      txd_pullup_en   <= mode == MODE_MODEM || hs_mode; // [RULE1]
      carrier_present <= mode == MODE_MODEM && carrier_detect_input; // [RULE2]
    end
  end

  // ==================================================================
  // Status: ready and buffer-full bits follow live, error bits sticky, set wins over clear
  always_comb begin
    next_status = status;
    if (wr && addr == ADDR_IRQ_CLR) begin
      next_status = status & ~wdata[ST_W-1:0];
    end
    next_status[ST_RX_READY]  = rx_full;
    next_status[ST_TX_READY]  = !tx_busy;
    next_status[ST_BUF_FULL]  = buf_full;
    if (rx_brk)               next_status[ST_BREAK]     = 1'b1; // [RULE4]
    if (rx_ferr)              next_status[ST_FRAME_ERR] = 1'b1; // [RULE3]
    if (rx_valid && rx_full)  next_status[ST_OVERRUN]   = 1'b1;
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      status <= '0;
      irq    <= 1'b0;
    end else begin
      status <= next_status;
      irq    <= |(next_status & irq_en);
    end
  end

  // ==================================================================
  // Read port, data valid one cycle after the strobe
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      rdata <= 32'h0000_0000;
    end else if (rd) begin
      unique case (addr)
        ADDR_CTRL:     rdata <= ctrl;
        ADDR_MODE:     rdata <= 32'(mode);
        ADDR_BAUD:     rdata <= 32'(baud);
        ADDR_STATUS:   rdata <= 32'(status);
        ADDR_IRQ_EN:   rdata <= 32'(irq_en);
        ADDR_RX_DATA:  rdata <= 32'(rx_hold);
        ADDR_DMA_CNT0: rdata <= 32'(dma_cnt0);
        ADDR_DMA_CNT1: rdata <= 32'(dma_cnt1);
        ADDR_LINE:     rdata <= {28'h0000000, carrier_present, rts_b, txd, rxd};
        default:       rdata <= 32'h0000_0000;
      endcase
    end else begin
      rdata <= 32'h0000_0000;
    end
  end
endmodule
`default_nettype wire

// ### dv/ushb_monitor.sv
// Port checker for the serial port core
`default_nettype none
module ushb_monitor
  import ushb_pkg::*;
(
  // Clock and reset
  input wire logic        clk_sys,
  input wire logic        rst_b,
  // Register port
  input wire logic [7:0]  addr,
  input wire logic [31:0] wdata,
  input wire logic        wr,
  input wire logic        rd,
  input wire logic [31:0] rdata,
  // Line and DMA side
  input wire logic        dma_rx_req,
  input wire logic        txd,
  input wire logic        txd_pullup_en,
  input wire logic        rts_b,
  input wire logic        carrier_detect_input,
  input wire logic        carrier_present,
  input wire logic        irq
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [1:0] mode_q;
  logic       dma_q;
  logic [5:0] ien_q;
  // ========
  // Shadow configuration, same write timing as the core
  always_ff @(posedge clk_sys) begin
    if (!rst_b) begin
      mode_q <= MODE_NORMAL;
      dma_q  <= 1'b0;
      ien_q  <= 6'h00;
    end else if (wr) begin
      if (addr == ADDR_MODE) mode_q <= wdata[1:0];
      if (addr == ADDR_CTRL) dma_q <= wdata[CTRL_DMA_EN];
      if (addr == ADDR_IRQ_EN) ien_q <= wdata[5:0];
    end
  end
  // ========
  // Properties
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_b);
  a_pullup_mode: assert property (txd_pullup_en ==
    $past(mode_q == MODE_MODEM || mode_q == MODE_HANDSHAKE))
    else $error("pull-up enable does not follow mode");
  a_modem_pullup: assert property (wr && addr == ADDR_MODE && wdata[1:0] == MODE_MODEM
    |-> ##2 txd_pullup_en) else $error("no pull-up after modem select");
  a_carrier_level: assert property
    (carrier_present == $past(mode_q == MODE_MODEM && carrier_detect_input))
    else $error("carrier polarity wrong");
  a_hs_rts_low: assert property (wr && addr == ADDR_MODE && !dma_q
    && wdata[1:0] == MODE_HANDSHAKE |-> ##2 !rts_b) else $error("rts not low");
  a_rdata_quiet: assert property (!$past(rd) |-> rdata == 32'h0)
    else $error("read data outside read slot");
  a_unmapped_rd: assert property (rd && addr == 8'h2C |=> rdata == 32'h0)
    else $error("unmapped read not zero");
  a_reset_vals: assert property ($rose(rst_b) |-> txd && rts_b && !irq && !txd_pullup_en)
    else $error("outputs not at reset level");
  a_irq_masked: assert property ($past(ien_q) == 6'h00 |-> !irq)
    else $error("interrupt while all masked");
  a_dma_idle: assert property (!dma_q |-> !dma_rx_req)
    else $error("dma request while dma off");
endmodule
bind ushb_core ushb_monitor mon_u (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .dma_rx_req(dma_rx_req), .txd(txd),
  .txd_pullup_en(txd_pullup_en), .rts_b(rts_b), .carrier_detect_input(carrier_detect_input),
  .carrier_present(carrier_present), .irq(irq));
`default_nettype wire

// ### dv/ushb_remote.sv
// Remote serial transmitter that drives the receive line
`default_nettype none
module ushb_remote #(
  parameter int BIT_CLKS = 32
) (
  // Clock
  input  wire logic clk_sys,
  // Serial line, idles high
  output var logic  rxd
);
  timeunit 1ns;
  timeprecision 1ns;
  initial rxd = 1'b1;
  task automatic hold_bit(input logic level);
    rxd <= level;
    repeat (BIT_CLKS) @(posedge clk_sys);
  endtask
  // Two stops give the receiver the guard it needs before a break
  task automatic send(input logic [7:0] data, input int stops);
    @(posedge clk_sys);
    hold_bit(1'b0);
    for (int i = 0; i < 8; i++) hold_bit(data[i]);
    repeat (stops) hold_bit(1'b1);
  endtask
  task automatic send_break();
    repeat (12) hold_bit(1'b0);
    rxd <= 1'b1;
  endtask
endmodule
`default_nettype wire

// ### dv/ushb_core_tb.sv
// Testbench for the serial port core
`default_nettype none
module ushb_core_tb
  import ushb_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [31:0] BRK_M = 32'h1 << ST_BREAK;
  localparam logic [31:0] FER_M = 32'h1 << ST_FRAME_ERR;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic [7:0]  addr = 8'h00;
  logic [31:0] wdata = 32'h0;
  logic        wr = 1'b0;
  logic        rd = 1'b0;
  logic        dma_rx_ack = 1'b0;
  logic        carrier_detect_input = 1'b0;
  logic [31:0] rdata;
  logic        dma_rx_req, rxd, txd, txd_pullup_en, rts_b, carrier_present, irq;
  int          fails = 0;
  int          total_checks = 0;
  int          cycles = 0;
  always #5 clk_sys = ~clk_sys;
  ushb_core dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .addr(addr), .wdata(wdata), .wr(wr),
    .rd(rd), .rdata(rdata), .dma_rx_req(dma_rx_req), .dma_rx_ack(dma_rx_ack), .rxd(rxd),
    .txd(txd), .txd_pullup_en(txd_pullup_en), .rts_b(rts_b),
    .carrier_detect_input(carrier_detect_input), .carrier_present(carrier_present), .irq(irq));
  ushb_remote remote_u (.clk_sys(clk_sys), .rxd(rxd));
  // ========
  // Bus and compare tasks
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    check({31'h0, got}, {31'h0, exp});
  endtask
  task automatic after(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask
  task automatic reg_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(posedge clk_sys);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    check(rdata & m, e);
  endtask
  // ========
  // Scenarios
  task automatic test_reset();
    rd_chk(ADDR_BAUD, 32'hFFFF, {16'h0, BAUD_RESET});
    rd_chk(8'h2C, 32'hFFFFFFFF, 32'h0);
    check({28'h0, txd, rts_b, irq, txd_pullup_en}, 32'hC);
    $display("test_reset done");
  endtask
  task automatic test_modes();
    reg_wr(ADDR_MODE, 32'(MODE_HANDSHAKE));
    after(1);
    chk1(txd_pullup_en, 1'b1);
    chk1(txd, 1'b1);
    chk1(rts_b, 1'b0);
    reg_wr(ADDR_MODE, 32'(MODE_MODEM));
    carrier_detect_input <= 1'b1;
    after(2);
    chk1(txd_pullup_en, 1'b1);
    chk1(carrier_present, 1'b1);
    @(posedge clk_sys);
    carrier_detect_input <= 1'b0;
    after(2);
    chk1(carrier_present, 1'b0);
    reg_wr(ADDR_MODE, 32'(MODE_NORMAL));
    after(1);
    chk1(txd_pullup_en, 1'b0);
    $display("test_modes done");
  endtask
  task automatic test_dma();
    reg_wr(ADDR_BAUD, 32'h1);
    reg_wr(ADDR_CTRL, 32'h5);
    reg_wr(ADDR_DMA_CNT0, 32'h2);
    reg_wr(ADDR_DMA_CNT1, 32'h2);
    reg_wr(ADDR_MODE, 32'(MODE_HANDSHAKE));
    after(1);
    chk1(rts_b, 1'b0);
    remote_u.send(8'hA5, 1);
    for (int i = 0; i < 400 && dma_rx_req !== 1'b1; i++) after(1);
    chk1(dma_rx_req, 1'b1);
    chk1(rts_b, 1'b1);
    @(posedge clk_sys);
    dma_rx_ack <= 1'b1;
    @(posedge clk_sys);
    dma_rx_ack <= 1'b0;
    #1;
    chk1(dma_rx_req, 1'b0);
    rd_chk(ADDR_RX_DATA, 32'hFF, 32'hA5);
    rd_chk(ADDR_STATUS, 32'h1 << ST_BUF_FULL, 32'h0);
    reg_wr(ADDR_CTRL, 32'h4);
    after(2);
    chk1(rts_b, 1'b0);
    reg_wr(ADDR_DMA_CNT0, 32'h0);
    after(2);
    chk1(rts_b, 1'b0);
    reg_wr(ADDR_DMA_CNT1, 32'h0);
    after(2);
    chk1(rts_b, 1'b1);
    $display("test_dma done");
  endtask
  task automatic test_break();
    reg_wr(ADDR_MODE, 32'(MODE_NORMAL));
    reg_wr(ADDR_CTRL, 32'h1);
    reg_wr(ADDR_IRQ_CLR, 32'h3F);
    reg_wr(ADDR_IRQ_EN, BRK_M);
    remote_u.send(8'h55, 1);
    remote_u.send_break();
    after(400);
    rd_chk(ADDR_STATUS, BRK_M | FER_M, FER_M);
    chk1(irq, 1'b0);
    reg_wr(ADDR_IRQ_CLR, 32'h3F);
    remote_u.send(8'h55, 2);
    remote_u.send_break();
    after(400);
    rd_chk(ADDR_STATUS, BRK_M, BRK_M);
    chk1(irq, 1'b1);
    reg_wr(ADDR_IRQ_CLR, 32'h3F);
    after(2);
    chk1(irq, 1'b0);
    $display("test_break done");
  endtask
  task automatic test_tx();
    logic [9:0] frame;
    frame = {1'b1, 8'h3C, 1'b0};
    reg_wr(ADDR_CTRL, 32'h2);
    reg_wr(ADDR_TX_DATA, 32'h3C);
    // Sample each bit near its middle, 32 clocks a bit at this baud
    after(15);
    for (int i = 0; i < 10; i++) begin
      chk1(txd, frame[i]);
      after(32);
    end
    chk1(txd, 1'b1);
    $display("test_tx done");
  endtask
  // ========
  // Verdict, run sequence and hang guard
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  initial begin
    repeat (6) @(posedge clk_sys);
    rst_b <= 1'b1;
    test_reset();
    test_modes();
    test_dma();
    test_break();
    test_tx();
    complete_run();
  end
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      fails++;
      $display("ERROR %0t: run hung", $time);
      complete_run();
    end
  end
endmodule
`default_nettype wire
